// ### inc/amp_ctl_pkg.sv
// shared constants, state encoding and register-size decoding for the control slave
// assumes a single core clock domain; included before all design files
`default_nettype none

package amp_ctl_pkg;

  // bus identity and subaddress map
  localparam logic [6:0]  DEV_ADDR      = 7'h36;
  localparam logic [7:0]  SHORT_LIMIT   = 8'h20;        // first four-byte subaddress
  localparam logic [7:0]  BQ_FIRST      = 8'h29;        // first biquad subaddress
  localparam logic [7:0]  BQ_LAST       = 8'h3A;        // last biquad subaddress
  localparam logic [7:0]  SHUTDOWN_SUB  = 8'h19;
  localparam logic [7:0]  OUT_MUX_SUB   = 8'h25;

  // reset values of the routing registers that leave the block
  localparam logic [7:0]  SHUTDOWN_RST  = 8'h30;
  localparam logic [31:0] OUT_MUX_RST   = 32'h0102_1345;

  // field widths and masks
  localparam logic [31:0] SHORT_MASK    = 32'h0000_00FF;
  localparam logic [31:0] COEF_MASK     = 32'h03FF_FFFF;
  localparam logic [31:0] LONG_MASK     = 32'hFFFF_FFFF;
  localparam logic [4:0]  SHORT_BYTES   = 5'h01;
  localparam logic [4:0]  LONG_BYTES    = 5'h04;
  localparam logic [4:0]  BQ_BYTES      = 5'h14;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam int          MEM_AW        = 11;           // subaddress plus word index

  // serial engine states, gray along the usual write and read paths
  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEVADDR = 4'h1,
    ST_DEVACK  = 4'h3,
    ST_SUB     = 4'h2,
    ST_SUBACK  = 4'h6,
    ST_WR      = 4'h7,
    ST_WRACK   = 4'h5,
    ST_RD      = 4'hB,
    ST_RDACK   = 4'hF
  } slave_state_t;

  // bytes one register takes on the bus
  function automatic logic [4:0] reg_bytes(input logic [7:0] sub);
    if (sub < SHORT_LIMIT) begin
      return SHORT_BYTES;
    end else if (sub >= BQ_FIRST && sub <= BQ_LAST) begin
      return BQ_BYTES;
    end else begin
      return LONG_BYTES;
    end
  endfunction : reg_bytes

  // bits a register really holds; the rest read as zero
  function automatic logic [31:0] reg_mask(input logic [7:0] sub);
    if (sub < SHORT_LIMIT) begin
      return SHORT_MASK;
    end else if (sub >= BQ_FIRST && sub <= BQ_LAST) begin
      return COEF_MASK;
    end else begin
      return LONG_MASK;
    end
  endfunction : reg_mask

endpackage : amp_ctl_pkg

`default_nettype wire

// ### verilog/reg_store.sv
// register storage: one write port, one read port with registered read data
// assumes writes and reads come from the same clock; contents are not reset
`default_nettype none

module reg_store #(
  parameter int AW = 11,
  parameter int DW = 32
) (
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  // write port
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // read port, registered
  always_ff @(posedge core_clk) begin
    rd_data <= mem_reg[rd_addr];
  end

endmodule : reg_store

`default_nettype wire

// ### verilog/amp_control_serial_slave.sv
// two-wire control slave: subaddressed short, long and coefficient registers
// assumes scl and sda arrive asynchronously from pins; master owns the clock
//
// Behaviour
// - answer only bus address 0x36
// - work at 100 kHz and 400 kHz
// - slave only, never stretch clock
// - bytes msb first, receiver acks each
// - start/stop are sda edges while scl high
// - data changes only while scl low
// - ack by holding sda low whole period
// - no limit on bytes per transfer
// - short subaddresses accept single and multi bytes
// - long subaddresses need four-byte multiples
// - read streams on while master acknowledges
// - unused register bits read as zero
// - incomplete register writes are dropped
// - sequential write advances per complete register
// - partial last register dropped, earlier kept
// - write: addr w0, subaddress, data, stop
// - read: subaddress write, restart, addr r1
// - acknowledge every written data byte
// - default routing 1 then 2, mux changes
`default_nettype none

module amp_control_serial_slave
  import amp_ctl_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  output var  logic [31:0] speaker_pins_mux,
  output var  logic [7:0]  shutdown_group
);

  slave_state_t state_reg;
  logic        scl_meta_reg, scl_s_reg, scl_d_reg;
  logic        sda_meta_reg, sda_s_reg, sda_d_reg;
  logic        master_ack_reg, commit_busy_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  rx_shift_reg, tx_shift_reg, tx_byte;
  logic [7:0]  rd_sub_reg, wr_sub_reg, commit_sub_reg;
  logic [4:0]  rd_byte_reg, wr_byte_reg, wr_byte_next;
  logic [2:0]  commit_idx_reg, commit_last;
  logic [31:0] stage_reg [0:4];
  logic [31:0] mem_rdata, rd_word;
  logic        scl_rise, scl_fall, start_det, stop_det;
  logic        addr_hit, byte_end, sub_done, wr_done, rd_done;

  // two-flop synchronisers then a history stage for edge detection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_meta_reg <= 1'b1;
      scl_s_reg    <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_s_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      scl_s_reg    <= scl_meta_reg;
      scl_d_reg    <= scl_s_reg;
      sda_meta_reg <= sda_in;
      sda_s_reg    <= sda_meta_reg;
      sda_d_reg    <= sda_s_reg;
    end
  end

  // bus events; 120 ns sampling lag fits well inside the 1.3 us low time
  assign scl_rise  = scl_s_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_s_reg & scl_d_reg;
  assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_det  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

  // byte boundaries seen by the engine
  assign addr_hit = (rx_shift_reg[7:1] == DEV_ADDR);
  assign byte_end = scl_fall && (bit_cnt_reg == BYTE_BITS);
  assign sub_done = byte_end && (state_reg == ST_SUB);
  assign wr_done  = byte_end && (state_reg == ST_WR);
  assign rd_done  = byte_end && (state_reg == ST_RD);

  // serial engine: shifts bits in on rising scl, moves on falling scl
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg      <= ST_IDLE;
      bit_cnt_reg    <= 4'h0;
      rx_shift_reg   <= 8'h00;
      master_ack_reg <= 1'b0;
    end else if (start_det) begin
      state_reg   <= ST_DEVADDR;
      bit_cnt_reg <= 4'h0;
    end else if (stop_det) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ST_DEVADDR, ST_SUB, ST_WR: begin
          if (scl_rise) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s_reg};
            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == ST_DEVADDR) begin
              state_reg <= addr_hit ? ST_DEVACK : ST_IDLE;
            end else if (state_reg == ST_SUB) begin
              state_reg <= ST_SUBACK;
            end else begin
              state_reg <= ST_WRACK;
            end
          end
        end
        ST_DEVACK: begin
          if (scl_fall) begin
            state_reg <= rx_shift_reg[0] ? ST_RD : ST_SUB;
          end
        end
        ST_SUBACK, ST_WRACK: begin
          if (scl_fall) begin
            state_reg <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= ST_RDACK;
          end
        end
        ST_RDACK: begin
          if (scl_rise) begin
            master_ack_reg <= ~sda_s_reg;
          end else if (scl_fall) begin
            state_reg <= master_ack_reg ? ST_RD : ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // read word picked out of storage, unused bits forced to zero
  assign rd_word = mem_rdata & reg_mask(rd_sub_reg);

  // byte to send: short registers in the low byte, long ones msb byte first
  always_comb begin
    tx_byte = rd_word[7:0];
    if (rd_sub_reg >= SHORT_LIMIT) begin
      case (rd_byte_reg[1:0])
        2'h0:    tx_byte = rd_word[31:24];
        2'h1:    tx_byte = rd_word[23:16];
        2'h2:    tx_byte = rd_word[15:8];
        default: tx_byte = rd_word[7:0];
      endcase
    end
  end

  // sda drive: only ever pulls low, changes right after scl falls
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sda_oe       <= 1'b0;
      tx_shift_reg <= 8'h00;
    end else if (start_det || stop_det) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      case (state_reg)
        ST_DEVADDR: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            sda_oe <= addr_hit;
          end
        end
        ST_SUB, ST_WR: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            sda_oe <= 1'b1;
          end
        end
        ST_DEVACK: begin
          sda_oe       <= rx_shift_reg[0] & ~tx_byte[7];
          tx_shift_reg <= {tx_byte[6:0], 1'b0};
        end
        ST_RD: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            sda_oe <= 1'b0;
          end else begin
            sda_oe       <= ~tx_shift_reg[7];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
          end
        end
        ST_RDACK: begin
          sda_oe       <= master_ack_reg & ~tx_byte[7];
          tx_shift_reg <= {tx_byte[6:0], 1'b0};
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // the data level is always low; the pin is driven only through sda_oe
  always_ff @(posedge core_clk) begin
    sda_out <= 1'b0;
  end

  // read pointer: set by the subaddress, steps byte by byte through registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_sub_reg  <= 8'h00;
      rd_byte_reg <= 5'h00;
    end else if (sub_done) begin
      rd_sub_reg  <= rx_shift_reg;
      rd_byte_reg <= 5'h00;
    end else if (rd_done) begin
      if (rd_byte_reg + 5'h01 == reg_bytes(rd_sub_reg)) begin
        rd_sub_reg  <= rd_sub_reg + 8'h01;
        rd_byte_reg <= 5'h00;
      end else begin
        rd_byte_reg <= rd_byte_reg + 5'h01;
      end
    end
  end

  assign wr_byte_next = wr_byte_reg + 5'h01;

  // write staging: a register is committed only once all its bytes arrived
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_sub_reg  <= 8'h00;
      wr_byte_reg <= 5'h00;
    end else if (start_det || stop_det) begin
      wr_byte_reg <= 5'h00;
    end else if (sub_done) begin
      wr_sub_reg  <= rx_shift_reg;
      wr_byte_reg <= 5'h00;
    end else if (wr_done) begin
      if (wr_sub_reg < SHORT_LIMIT) begin
        stage_reg[0] <= {24'h00_0000, rx_shift_reg};
      end else begin
        stage_reg[wr_byte_reg[4:2]] <= {stage_reg[wr_byte_reg[4:2]][23:0], rx_shift_reg};
      end
      if (wr_byte_next == reg_bytes(wr_sub_reg)) begin
        wr_byte_reg <= 5'h00;
        wr_sub_reg  <= wr_sub_reg + 8'h01;
      end else begin
        wr_byte_reg <= wr_byte_next;
      end
    end
  end

  assign commit_last = (reg_bytes(commit_sub_reg) == BQ_BYTES) ? 3'h4 : 3'h0;

  // commit sequencer: copies staged words into storage, one per cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      commit_busy_reg <= 1'b0;
      commit_idx_reg  <= 3'h0;
      commit_sub_reg  <= 8'h00;
    end else if (wr_done && wr_byte_next == reg_bytes(wr_sub_reg)) begin
      commit_busy_reg <= 1'b1;
      commit_idx_reg  <= 3'h0;
      commit_sub_reg  <= wr_sub_reg;
    end else if (commit_busy_reg) begin
      commit_idx_reg <= commit_idx_reg + 3'h1;
      if (commit_idx_reg == commit_last) begin
        commit_busy_reg <= 1'b0;
      end
    end
  end

  // routing registers that leave the block, updated at commit
  always_ff @(posedge core_clk) begin
    if (srst) begin
      speaker_pins_mux <= OUT_MUX_RST;
      shutdown_group   <= SHUTDOWN_RST;
    end else if (commit_busy_reg && commit_idx_reg == 3'h0) begin
      if (commit_sub_reg == OUT_MUX_SUB) begin
        speaker_pins_mux <= stage_reg[0];
      end
      if (commit_sub_reg == SHUTDOWN_SUB) begin
        shutdown_group <= stage_reg[0][7:0];
      end
    end
  end

  reg_store #(
    .AW (MEM_AW),
    .DW (32)
  ) u_store (
    .core_clk (core_clk),
    .wr_en    (commit_busy_reg),
    .wr_addr  ({commit_sub_reg, commit_idx_reg}),
    .wr_data  (stage_reg[commit_idx_reg] & reg_mask(commit_sub_reg)),
    .rd_addr  ({rd_sub_reg, rd_byte_reg[4:2]}),
    .rd_data  (mem_rdata)
  );

  // checks on the bus behaviour and the commit sequencer
  a_addr_match: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_DEVACK && $past(state_reg) == ST_DEVADDR) |-> rx_shift_reg[7:1] == DEV_ADDR)
    else $error("acknowledged a foreign address");
  a_ack_held: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_DEVACK && !start_det && !stop_det) |-> sda_oe)
    else $error("address ack not held low");
  a_wr_ack: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_WRACK || state_reg == ST_SUBACK) |-> sda_oe)
    else $error("data byte not acknowledged");
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_IDLE) |-> !sda_oe)
    else $error("sda driven while idle");
  a_start_addr: assert property (@(posedge core_clk) disable iff (srst)
    start_det |=> (state_reg == ST_DEVADDR && bit_cnt_reg == 4'h0 && !sda_oe))
    else $error("start not taken");
  a_stop_idle: assert property (@(posedge core_clk) disable iff (srst)
    stop_det |=> (state_reg == ST_IDLE && wr_byte_reg == 5'h00))
    else $error("stop not taken or partial kept");
  a_sda_low_phase: assert property (@(posedge core_clk) disable iff (srst)
    ($changed(sda_oe) && !$past(start_det) && !$past(stop_det)) |-> !$past(scl_s_reg))
    else $error("sda changed while scl high");
  a_rdack_release: assert property (@(posedge core_clk) disable iff (srst)
    (state_reg == ST_RDACK) |-> !sda_oe)
    else $error("sda driven in master ack slot");
  a_commit_whole: assert property (@(posedge core_clk) disable iff (srst)
    $rose(commit_busy_reg) |-> $past(wr_byte_reg) + 5'h01 == reg_bytes(commit_sub_reg))
    else $error("commit of incomplete register");
  a_commit_len: assert property (@(posedge core_clk) disable iff (srst)
    ($rose(commit_busy_reg) && commit_sub_reg >= BQ_FIRST && commit_sub_reg <= BQ_LAST)
      |-> commit_busy_reg [*5] ##1 !commit_busy_reg)
    else $error("coefficient commit not five words");

endmodule : amp_control_serial_slave

`default_nettype wire

// ### test/i2c_master_model.sv
// two-wire bus master model standing on the far side of the control slave
// assumes pull-ups on both lines; changes its lines at the falling core edge
`default_nettype none

module i2c_master_model (
  input  wire logic core_clk,
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int QTR = 16;  // quarter bit, about 390 kHz
  int            rate_div = 1;  // 4 stretches every phase, about 98 kHz

  // both lines released at time zero
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n * rate_div) @(negedge core_clk);
  endtask : hold

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_low = 1'b0;
    hold(QTR);
    scl = 1'b1;
    hold(QTR);
    sda_low = 1'b1;
    hold(QTR);
    scl = 1'b0;
    hold(QTR);
  endtask : start

  // stop: sda rises while scl is high
  task automatic stop();
    sda_low = 1'b1;
    hold(QTR);
    scl = 1'b1;
    hold(QTR);
    sda_low = 1'b0;
    hold(2 * QTR);
  endtask : stop

  // one clock period, sda set only while scl is low
  task automatic bit_cycle(input logic drv, output logic seen);
    sda_low = ~drv;
    hold(QTR);
    scl = 1'b1;
    hold(QTR);
    seen = sda_in;
    hold(QTR);
    scl = 1'b0;
    hold(QTR);
  endtask : bit_cycle

  // byte out msb first, then the slave's acknowledge
  task automatic wr_byte(input logic [7:0] data, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(data[i], seen);
    end
    bit_cycle(1'b1, seen);
    ack = ~seen;
  endtask : wr_byte

  // byte in msb first; the last one is not acknowledged
  task automatic rd_byte(input logic last, output logic [7:0] data);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, seen);
      data[i] = seen;
    end
    bit_cycle(last, seen);
  endtask : rd_byte

endmodule : i2c_master_model

`default_nettype wire

// ### test/amp_control_serial_slave_tb_top.sv
// self-checking bench for the two-wire control slave
// assumes amp_ctl_pkg is compiled first; the master model drives the bus
`default_nettype none

module amp_control_serial_slave_tb_top
  import amp_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LIMIT = 95000;

  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic        sda_wire;
  logic [31:0] speaker_pins_mux;
  logic [7:0]  shutdown_group;
  logic [7:0]  wbuf [0:23];
  logic [7:0]  rbuf [0:23];
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc_cnt   = 0;

  always #20 core_clk = ~core_clk;

  // wired-and bus with pull-up
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  amp_control_serial_slave u_dut (
    .core_clk         (core_clk),
    .srst             (srst),
    .scl_in           (scl),
    .sda_in           (sda_wire),
    .sda_out          (sda_out),
    .sda_oe           (sda_oe),
    .speaker_pins_mux (speaker_pins_mux),
    .shutdown_group   (shutdown_group)
  );

  i2c_master_model u_mst (
    .core_clk (core_clk),
    .sda_in   (sda_wire),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  // hang guard
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic [7:0] data);
    logic ack;
    u_mst.wr_byte(data, ack);
    check({31'h0, ack}, 32'h1);
  endtask : send

  // write n bytes of wbuf from subaddress sub
  task automatic wr_regs(input logic [7:0] sub, input int n);
    u_mst.start();
    send({DEV_ADDR, 1'b0});
    send(sub);
    for (int i = 0; i < n; i++) begin
      send(wbuf[i]);
    end
    u_mst.stop();
  endtask : wr_regs

  // read n bytes into rbuf from subaddress sub
  task automatic rd_regs(input logic [7:0] sub, input int n);
    u_mst.start();
    send({DEV_ADDR, 1'b0});
    send(sub);
    u_mst.start();
    send({DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      u_mst.rd_byte(i == n - 1, rbuf[i]);
    end
    u_mst.stop();
  endtask : rd_regs

  task automatic test_reset();
    check(speaker_pins_mux, OUT_MUX_RST);
    check({24'h0, shutdown_group}, {24'h0, SHUTDOWN_RST});
    check({31'h0, sda_oe}, 32'h0);
    $display("test_reset done");
  endtask : test_reset

  // foreign addresses are neither acknowledged nor followed
  task automatic test_foreign();
    logic ack;
    for (int i = 0; i < 2; i++) begin
      u_mst.start();
      u_mst.wr_byte(i == 0 ? 8'h6E : 8'h2C, ack);
      check({31'h0, ack}, 32'h0);
      u_mst.wr_byte({DEV_ADDR, 1'b0}, ack);
      check({31'h0, ack}, 32'h0);
      u_mst.stop();
    end
    $display("test_foreign done");
  endtask : test_foreign

  task automatic test_short();
    wbuf[0] = 8'hA5;
    wr_regs(8'h07, 1);
    for (int i = 0; i < 4; i++) begin
      wbuf[i] = 8'h3C ^ (8'h11 * i[7:0]);
    end
    wr_regs(8'h10, 4);
    rd_regs(8'h07, 1);
    check({24'h0, rbuf[0]}, 32'hA5);
    rd_regs(8'h10, 4);
    for (int i = 0; i < 4; i++) begin
      check({24'h0, rbuf[i]}, {24'h0, 8'h3C ^ (8'h11 * i[7:0])});
    end
    wbuf[0] = 8'h5A;
    u_mst.rate_div = 4;
    wr_regs(SHUTDOWN_SUB, 1);
    u_mst.rate_div = 1;
    check({24'h0, shutdown_group}, 32'h5A);
    $display("test_short done");
  endtask : test_short

  // long registers, sequential advance and dropped partial sets
  task automatic test_long();
    {wbuf[0], wbuf[1], wbuf[2], wbuf[3]} = 32'h1234_5678;
    {wbuf[4], wbuf[5], wbuf[6], wbuf[7]} = 32'hCAFE_F00D;
    wr_regs(OUT_MUX_SUB, 8);
    check(speaker_pins_mux, 32'h1234_5678);
    {wbuf[0], wbuf[1], wbuf[2], wbuf[3]} = 32'h8765_4321;
    {wbuf[4], wbuf[5]} = 16'hAABB;
    wr_regs(OUT_MUX_SUB, 6);
    check(speaker_pins_mux, 32'h8765_4321);
    wr_regs(OUT_MUX_SUB, 3);
    check(speaker_pins_mux, 32'h8765_4321);
    rd_regs(OUT_MUX_SUB, 8);
    check({rbuf[0], rbuf[1], rbuf[2], rbuf[3]}, 32'h8765_4321);
    check({rbuf[4], rbuf[5], rbuf[6], rbuf[7]}, 32'hCAFE_F00D);
    $display("test_long done");
  endtask : test_long

  // five-word coefficient block, masked top bits, short write dropped
  task automatic test_biquad();
    for (int i = 0; i < 20; i++) begin
      wbuf[i] = 8'hC0 | i[7:0];
    end
    wr_regs(BQ_FIRST, 20);
    for (int i = 0; i < 16; i++) begin
      wbuf[i] = 8'hFF;
    end
    wr_regs(BQ_FIRST, 16);
    rd_regs(BQ_FIRST, 20);
    for (int i = 0; i < 20; i++) begin
      check({24'h0, rbuf[i]}, {24'h0, (8'hC0 | i[7:0]) & (i % 4 == 0 ? 8'h03 : 8'hFF)});
    end
    $display("test_biquad done");
  endtask : test_biquad

  // main sequence
  initial begin
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    repeat (5) @(negedge core_clk);
    test_reset();
    test_foreign();
    test_short();
    test_long();
    test_biquad();
    test_done();
  end

endmodule : amp_control_serial_slave_tb_top

`default_nettype wire
